//--- common/mgmt_reg_bank_defines.vh
// Constants for the management register bank: indices, fields, timing.
// Assumes a 25 MHz core clock and 5-bit register indices.
`ifndef MGMT_REG_BANK_DEFINES_VH
`define MGMT_REG_BANK_DEFINES_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define IDX_CTRL        5'h00
`define IDX_STAT        5'h01
`define IDX_MISC        5'h1B
`define IDX_EVT         5'h1D

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTRL_SOFT_RST   15
`define CTRL_RESTART    9
`define CTRL_RW_MASK    16'h7D80
`define CTRL_RST_VAL    16'h0000

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define STAT_FIXED      16'h7809
`define STAT_AN_DONE    5
`define STAT_RFAULT     4
`define STAT_LINK       2
`define STAT_JABBER     1

// ------------------------------------------------------------
// Miscellaneous register fields
// ------------------------------------------------------------
`define MISC_WC         15
`define MISC_ANY_CLR    14
`define MISC_SS         13
`define MISC_WO         12
`define MISC_CFG_RST    8'h00

// ------------------------------------------------------------
// Soft reset timing
// ------------------------------------------------------------
`define SRST_MAX_MS     500
`define CLK_KHZ         25000
`define SRST_CYCLES     (`SRST_MAX_MS * `CLK_KHZ)

`endif

//--- hdl/status_latch.v
// One latching status bit, latch-high or latch-low.
// Assumes release is a one-cycle pulse on a completed register read.
`timescale 1ns/1ns

module status_latch #(
	parameter HIGH = 1
)(
	input  wire core_clk,
	input  wire rst,
	input  wire soft_clr,
	input  wire cond,
	input  wire release_rd,
	output reg  state_ff
);

reg nxt_state;

// ------------------------------------------------------------
// Latch update
// ------------------------------------------------------------
always @*
begin
	if (soft_clr)
		nxt_state = 1'b0;
	else if (HIGH != 0)
		nxt_state = cond | (state_ff & ~release_rd);
	else
		nxt_state = cond & (state_ff | release_rd);
end

always @(posedge core_clk or posedge rst)
begin
	if (rst)
		state_ff <= 1'b0;
	else
		state_ff <= nxt_state;
end

endmodule

//--- hdl/mgmt_reg_bank.v
// Management register bank with per-bit access attributes.
// Assumes one-cycle read and write strobes synchronous to core_clk.
//
// Operation
// - Registers are selected by their decimal index on the management port.
// - Read-only bits return their value; writes leave them unchanged.
// - Write-only bits take writes; read value is unspecified.
// - Write-one-to-clear bits clear on a written one, not on zero.
// - Write-anything-to-clear bits clear on any write to them.
// - Clear-on-read bits return contents then clear; writes ignored.
// - Latch-low bit holds its low until its register is read.
// - Latch-high bit stays high until read, even if condition left.
// - After read, latch-high follows the condition's current state.
// - Self-clearing bit returns to zero alone; writing zero ignored.
// - Self-setting bit returns to one alone; writing one keeps its current value.
// - Keep-on-soft-reset bits hold their state through soft reset.
// - Read-write bits take writes and read back the current setting.
// - Readable write-anything-clear bit reads current, clears on write.
// - Combined attributes such as read-write self-clearing act together.
// - Soft reset returns all bits to their reset values except keep-on-soft-reset ones.
// - Soft reset completes within the maximum time after being set.
`timescale 1ns/1ns
`include "mgmt_reg_bank_defines.vh"

module mgmt_reg_bank #(
	parameter [15:0] STAT_FIXED  = `STAT_FIXED,
	parameter [31:0] SRST_CYCLES = `SRST_CYCLES,
	parameter        EVT_W       = 8
)(
	input  wire             core_clk,
	input  wire             rst,
	input  wire             mgmt_rd,
	input  wire             mgmt_wr,
	input  wire [4:0]       mgmt_idx,
	input  wire [15:0]      mgmt_wdata,
	input  wire             an_done,
	input  wire             remote_fault,
	input  wire             link_ok,
	input  wire             jabber,
	input  wire [EVT_W-1:0] evt_in,
	input  wire             wc_evt,
	input  wire             write_any_clear_evt,
	output reg  [15:0]      mgmt_rdata_ff,
	output reg  [15:0]      ctrl_ff,
	output reg  [7:0]       misc_cfg_ff,
	output reg              wo_ff,
	output reg              ss_ff,
	output reg              wc_ff,
	output reg              write_any_clear_ff
);

localparam [2:0] LATCH_HIGH = 3'b101;

// ------------------------------------------------------------
// Index decode
// ------------------------------------------------------------
function hit;
	input [4:0] idx;
	input [4:0] target;
	begin
		hit = (idx == target);
	end
endfunction

wire wr_ctrl = mgmt_wr & hit(mgmt_idx, `IDX_CTRL);
wire wr_misc = mgmt_wr & hit(mgmt_idx, `IDX_MISC);
wire rd_stat = mgmt_rd & hit(mgmt_idx, `IDX_STAT);
wire rd_evt  = mgmt_rd & hit(mgmt_idx, `IDX_EVT);

// ------------------------------------------------------------
// Soft reset timer
// ------------------------------------------------------------
reg  [23:0] srst_cnt_ff;
reg  [23:0] nxt_srst_cnt;
wire        srst_done;

assign srst_done = ctrl_ff[`CTRL_SOFT_RST] &
	(srst_cnt_ff == SRST_CYCLES[23:0] - 24'h000001);

always @*
begin
	if (ctrl_ff[`CTRL_SOFT_RST] && !srst_done)
		nxt_srst_cnt = srst_cnt_ff + 24'h000001;
	else
		nxt_srst_cnt = 24'h000000;
end

// ------------------------------------------------------------
// Status latches
// ------------------------------------------------------------
wire [2:0] lat_cond = {remote_fault, link_ok, jabber};
wire [2:0] lat_q;

genvar g;
generate
	for (g = 0; g < 3; g = g + 1)
	begin : g_lat
		status_latch #(
			.HIGH (LATCH_HIGH[g])
		) u_lat (
			.core_clk   (core_clk),
			.rst        (rst),
			.soft_clr   (srst_done),
			.cond       (lat_cond[g]),
			.release_rd (rd_stat),
			.state_ff   (lat_q[g])
		);
	end
endgenerate

// ------------------------------------------------------------
// Next-state logic
// ------------------------------------------------------------
reg [15:0]      nxt_ctrl;
reg [7:0]       nxt_cfg;
reg             nxt_wo;
reg             nxt_ss;
reg             nxt_wc;
reg             nxt_write_any_clear;
reg [EVT_W-1:0] evt_ff;
reg [EVT_W-1:0] nxt_evt;
reg [15:0]      nxt_rdata;

always @*
begin
	nxt_ctrl = ctrl_ff;
	nxt_ctrl[`CTRL_RESTART] = 1'b0;
	if (wr_ctrl)
	begin
		nxt_ctrl = (ctrl_ff & ~`CTRL_RW_MASK) |
			(mgmt_wdata & `CTRL_RW_MASK);
		nxt_ctrl[`CTRL_RESTART] = mgmt_wdata[`CTRL_RESTART];
		nxt_ctrl[`CTRL_SOFT_RST] = ctrl_ff[`CTRL_SOFT_RST] |
			mgmt_wdata[`CTRL_SOFT_RST];
	end
	if (srst_done)
		nxt_ctrl = `CTRL_RST_VAL;

	nxt_cfg = misc_cfg_ff;
	nxt_wo  = wo_ff;
	nxt_ss  = 1'b1;
	nxt_wc  = wc_ff;
	nxt_write_any_clear = write_any_clear_ff;
	if (wr_misc)
	begin
		nxt_cfg = mgmt_wdata[7:0];
		nxt_wo  = mgmt_wdata[`MISC_WO];
		nxt_ss  = mgmt_wdata[`MISC_SS] ? ss_ff : 1'b0;
		if (mgmt_wdata[`MISC_WC])
			nxt_wc = 1'b0;
		nxt_write_any_clear = 1'b0;
	end
	if (wc_evt)
		nxt_wc = 1'b1;
	if (write_any_clear_evt)
		nxt_write_any_clear = 1'b1;

	nxt_evt = evt_ff;
	if (rd_evt)
		nxt_evt = {EVT_W{1'b0}};
	nxt_evt = nxt_evt | evt_in;

	if (srst_done)
	begin
		nxt_wo  = 1'b0;
		nxt_ss  = 1'b1;
		nxt_wc  = 1'b0;
		nxt_write_any_clear = 1'b0;
		nxt_evt = {EVT_W{1'b0}};
	end

	nxt_rdata = 16'h0000;
	if (hit(mgmt_idx, `IDX_CTRL))
		nxt_rdata = ctrl_ff;
	else if (hit(mgmt_idx, `IDX_STAT))
	begin
		nxt_rdata = STAT_FIXED;
		nxt_rdata[`STAT_AN_DONE] = an_done;
		nxt_rdata[`STAT_RFAULT]  = lat_q[2];
		nxt_rdata[`STAT_LINK]    = lat_q[1];
		nxt_rdata[`STAT_JABBER]  = lat_q[0];
	end
	else if (hit(mgmt_idx, `IDX_MISC))
		nxt_rdata = {wc_ff, write_any_clear_ff, ss_ff, 5'h00,
			misc_cfg_ff};
	else if (hit(mgmt_idx, `IDX_EVT))
		nxt_rdata = {{(16-EVT_W){1'b0}}, evt_ff};
end

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
always @(posedge core_clk or posedge rst)
begin
	if (rst)
	begin
		ctrl_ff       <= `CTRL_RST_VAL;
		misc_cfg_ff   <= `MISC_CFG_RST;
		wo_ff         <= 1'b0;
		ss_ff         <= 1'b1;
		wc_ff         <= 1'b0;
		write_any_clear_ff <= 1'b0;
		evt_ff        <= {EVT_W{1'b0}};
		srst_cnt_ff   <= 24'h000000;
		mgmt_rdata_ff <= 16'h0000;
	end
	else
	begin
		ctrl_ff     <= nxt_ctrl;
		misc_cfg_ff <= nxt_cfg;
		wo_ff       <= nxt_wo;
		ss_ff       <= nxt_ss;
		wc_ff       <= nxt_wc;
		write_any_clear_ff <= nxt_write_any_clear;
		evt_ff      <= nxt_evt;
		srst_cnt_ff <= nxt_srst_cnt;
		if (mgmt_rd)
			mgmt_rdata_ff <= nxt_rdata;
	end
end

endmodule

//--- verif/mgmt_reg_bank_asserts.sv
// Port checker for the management register bank.
// Bound into every mgmt_reg_bank instance.
`timescale 1ns/1ns
module mgmt_reg_bank_asserts(
	input wire        core_clk,
	input wire        rst,
	input wire        mgmt_rd,
	input wire        mgmt_wr,
	input wire [4:0]  mgmt_idx,
	input wire [15:0] mgmt_wdata,
	input wire        an_done,
	input wire        remote_fault,
	input wire        jabber,
	input wire        wc_evt,
	input wire        write_any_clear_evt,
	input wire [15:0] mgmt_rdata_ff,
	input wire [15:0] ctrl_ff,
	input wire        ss_ff,
	input wire        wc_ff,
	input wire        write_any_clear_ff
);
	wire rd_st = mgmt_rd && mgmt_idx == 5'h01;
	wire wr_mc = mgmt_wr && mgmt_idx == 5'h1B;
	reg  jab_seen_ff;
	// Jabber latch mirror, blanked while soft reset runs
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			jab_seen_ff <= 1'b0;
		else if (ctrl_ff[15])
			jab_seen_ff <= 1'b0;
		else
			jab_seen_ff <= jabber | (jab_seen_ff & ~rd_st);
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_status_read_only:
		assert property (rd_st |=> mgmt_rdata_ff[15:11] == 5'h0F
		&& mgmt_rdata_ff[5] == $past(an_done)) else $error("status bits");
	a_latch_high_hold:
		assert property (remote_fault && !ctrl_ff[15] ##1 rd_st
		|=> mgmt_rdata_ff[4]) else $error("fault latch");
	a_jabber_latch_hold:
		assert property (rd_st && jab_seen_ff |=> mgmt_rdata_ff[1])
		else $error("jabber latch");
	a_ctrl_write_back:
		assert property (mgmt_wr && mgmt_idx == 5'h00 && !ctrl_ff[15]
		|=> ctrl_ff == ($past(mgmt_wdata) & 16'hFF80)) else $error("ctrl");
	a_restart_self_clear:
		assert property (ctrl_ff[9] && !mgmt_wr |=> !ctrl_ff[9])
		else $error("restart bit");
	a_wc_one_clears:
		assert property (wr_mc && mgmt_wdata[15] && !wc_evt |=> !wc_ff)
		else $error("wc clear");
	a_wc_zero_keeps:
		assert property (wr_mc && !mgmt_wdata[15] && wc_ff && !ctrl_ff[15]
		|=> wc_ff)
		else $error("wc keep");
	a_any_write_clears:
		assert property (wr_mc && !write_any_clear_evt
		|=> !write_any_clear_ff) else $error("write any clear");
	a_self_set_return:
		assert property (!ss_ff && !(wr_mc && !mgmt_wdata[13]) |=> ss_ff)
		else $error("self set");
	cover property (mgmt_rd && mgmt_idx == 5'h1D);
	cover property ($rose(ctrl_ff[15]));
	cover property (!ss_ff);
endmodule
bind mgmt_reg_bank mgmt_reg_bank_asserts u_chk (
	.core_clk            (core_clk),
	.rst                 (rst),
	.mgmt_rd             (mgmt_rd),
	.mgmt_wr             (mgmt_wr),
	.mgmt_idx            (mgmt_idx),
	.mgmt_wdata          (mgmt_wdata),
	.an_done             (an_done),
	.remote_fault        (remote_fault),
	.jabber              (jabber),
	.wc_evt              (wc_evt),
	.write_any_clear_evt (write_any_clear_evt),
	.mgmt_rdata_ff       (mgmt_rdata_ff),
	.ctrl_ff             (ctrl_ff),
	.ss_ff               (ss_ff),
	.wc_ff               (wc_ff),
	.write_any_clear_ff  (write_any_clear_ff)
);

//--- verif/mgmt_host.sv
// Station manager model: one-cycle read and write strobes.
// Drives at the falling edge; idle index and data inverted.
`timescale 1ns/1ns
module mgmt_host(
	input  wire        core_clk,
	input  wire [15:0] mgmt_rdata_ff,
	output reg         mgmt_rd,
	output reg         mgmt_wr,
	output reg  [4:0]  mgmt_idx,
	output reg  [15:0] mgmt_wdata
);
	initial
	begin
		{mgmt_rd, mgmt_wr, mgmt_idx, mgmt_wdata} = 23'h000000;
	end
	task rd(input [4:0] i, output [15:0] q);
	begin
		@(negedge core_clk);
		{mgmt_rd, mgmt_idx} = {1'b1, i};
		@(negedge core_clk);
		{mgmt_rd, mgmt_idx} = {1'b0, ~i};
		q = mgmt_rdata_ff;
	end
	endtask
	task wr(input [4:0] i, input [15:0] v);
	begin
		@(negedge core_clk);
		{mgmt_wr, mgmt_idx} = {1'b1, i};
		mgmt_wdata = i == 5'h00 ? v & 16'hFF80 : v;
		@(negedge core_clk);
		{mgmt_wr, mgmt_idx, mgmt_wdata} = {1'b0, ~i, ~mgmt_wdata};
	end
	endtask
endmodule

//--- verif/mgmt_reg_bank_test.sv
// Self-checking bench for the management register bank.
// Soft reset timer shortened to 8 cycles.
`timescale 1ns/1ns
module mgmt_reg_bank_test;
	reg         core_clk, rst, an_done, remote_fault, link_ok, jabber;
	reg         wc_evt, write_any_clear_evt;
	reg  [7:0]  evt_in;
	reg  [15:0] d;
	wire        mgmt_rd, mgmt_wr, wo_ff, ss_ff, wc_ff;
	wire        write_any_clear_ff;
	wire [4:0]  mgmt_idx;
	wire [7:0]  misc_cfg_ff;
	wire [15:0] mgmt_wdata, mgmt_rdata_ff, ctrl_ff;
	wire [15:0] misc_bits;
	integer     miscompares, comparisons, n;
	assign misc_bits = {wc_ff, write_any_clear_ff, wo_ff, ss_ff, 4'h0,
		misc_cfg_ff};
	mgmt_reg_bank #(
		.SRST_CYCLES (32'h00000008)
	) u_mgmt_reg_bank (
		.core_clk            (core_clk),
		.rst                 (rst),
		.mgmt_rd             (mgmt_rd),
		.mgmt_wr             (mgmt_wr),
		.mgmt_idx            (mgmt_idx),
		.mgmt_wdata          (mgmt_wdata),
		.an_done             (an_done),
		.remote_fault        (remote_fault),
		.link_ok             (link_ok),
		.jabber              (jabber),
		.evt_in              (evt_in),
		.wc_evt              (wc_evt),
		.write_any_clear_evt (write_any_clear_evt),
		.mgmt_rdata_ff       (mgmt_rdata_ff),
		.ctrl_ff             (ctrl_ff),
		.misc_cfg_ff         (misc_cfg_ff),
		.wo_ff               (wo_ff),
		.ss_ff               (ss_ff),
		.wc_ff               (wc_ff),
		.write_any_clear_ff  (write_any_clear_ff)
	);
	mgmt_host u_mgmt_host (
		.core_clk      (core_clk),
		.mgmt_rdata_ff (mgmt_rdata_ff),
		.mgmt_rd       (mgmt_rd),
		.mgmt_wr       (mgmt_wr),
		.mgmt_idx      (mgmt_idx),
		.mgmt_wdata    (mgmt_wdata)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task chk(input [15:0] g, input [15:0] e);
	begin
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	task results;
	begin
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task t_status;
	begin
		@(negedge core_clk);
		{an_done, remote_fault, link_ok, jabber} = 4'hF;
		@(negedge core_clk);
		jabber = 1'b0;
		u_mgmt_host.wr(5'h01, 16'h0000);
		u_mgmt_host.rd(5'h01, d);
		chk(d & 16'hF83F, 16'h783B);
		u_mgmt_host.rd(5'h01, d);
		chk(d & 16'hF83F, 16'h783D);
		@(negedge core_clk);
		link_ok = 1'b0;
		@(negedge core_clk);
		link_ok = 1'b1;
		u_mgmt_host.rd(5'h00, d);
		u_mgmt_host.rd(5'h01, d);
		chk(d & 16'hF83F, 16'h7839);
		u_mgmt_host.rd(5'h01, d);
		chk(d & 16'hF83F, 16'h783D);
	end
	endtask
	task t_ctrl;
	begin
		u_mgmt_host.wr(5'h00, 16'h7FFF);
		chk(ctrl_ff, 16'h7F80);
		@(negedge core_clk);
		chk(ctrl_ff, 16'h7D80);
		u_mgmt_host.rd(5'h00, d);
		chk(d & 16'hFF80, 16'h7D80);
		u_mgmt_host.rd(5'h05, d);
		chk(d, 16'h0000);
	end
	endtask
	task t_misc;
	begin
		@(negedge core_clk);
		{wc_evt, write_any_clear_evt} = 2'h3;
		@(negedge core_clk);
		{wc_evt, write_any_clear_evt} = 2'h0;
		u_mgmt_host.wr(5'h1B, 16'h10A5);
		chk(misc_bits, 16'hA0A5);
		@(negedge core_clk);
		chk(misc_bits, 16'hB0A5);
		u_mgmt_host.wr(5'h1B, 16'hA0A5);
		chk(misc_bits, 16'h10A5);
	end
	endtask
	task t_events;
	begin
		@(negedge core_clk);
		evt_in = 8'h5A;
		@(negedge core_clk);
		evt_in = 8'h00;
		u_mgmt_host.wr(5'h1D, 16'h0000);
		u_mgmt_host.rd(5'h1D, d);
		chk(d, 16'h005A);
		u_mgmt_host.rd(5'h1D, d);
		chk(d, 16'h0000);
	end
	endtask
	task t_soft;
	begin
		u_mgmt_host.wr(5'h1B, 16'h10A5);
		@(negedge core_clk);
		{wc_evt, write_any_clear_evt, evt_in} = 10'h3FF;
		@(negedge core_clk);
		{wc_evt, write_any_clear_evt, evt_in} = 10'h000;
		u_mgmt_host.wr(5'h00, 16'h8000);
		chk(ctrl_ff, 16'h8000);
		n = 0;
		while (ctrl_ff[15] && n < 20)
		begin
			@(negedge core_clk);
			n = n + 1;
		end
		chk(n[15:0], 16'h0008);
		chk({ctrl_ff[15:8], misc_cfg_ff}, 16'h00A5);
		chk(misc_bits, 16'h10A5);
		u_mgmt_host.rd(5'h1D, d);
		chk(d, 16'h0000);
	end
	endtask
	initial
	begin
		{rst, an_done, remote_fault, link_ok, jabber} = 5'h10;
		{wc_evt, write_any_clear_evt, evt_in} = 10'h000;
		miscompares = 0;
		comparisons = 0;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		t_status;
		t_ctrl;
		t_misc;
		t_events;
		t_soft;
		results;
	end
	initial
	begin
		#80000;
		miscompares = miscompares + 1;
		results;
	end
endmodule
